// [hdl/mem_space_pkg.sv]
// Constants, enumerations and decode tables for the external memory space block.
// Assumes a single core clock; every consumer imports the whole package.
package mem_space_pkg;

  // Machine cycle of four clocks
  localparam int unsigned CLK_PER_MCYCLE = 4;
  localparam logic [1:0] PHASE_LAST = 2'h3;
  localparam logic [1:0] PHASE_CAPTURE = 2'h2;

  // Vector placement: base plus index times eight
  localparam logic [15:0] RESET_VECTOR = 16'h0000;
  localparam logic [15:0] VEC_BASE = 16'h0003;
  localparam int unsigned VEC_SHIFT = 3;

  // Memory indices, lowest index wins on overlap
  localparam int unsigned NUM_MEMS = 4;
  localparam int unsigned MEM_CTRL = 0;
  localparam int unsigned MEM_SRAM = 1;
  localparam int unsigned MEM_MAIN = 2;
  localparam int unsigned MEM_SEC = 3;

  // Segment decode equations: (addr & mask) == base, optional page match
  localparam logic [15:0] SEG_BASE [NUM_MEMS] = '{16'h7F00, 16'h2000, 16'h8000, 16'h0000};
  localparam logic [15:0] SEG_MASK [NUM_MEMS] = '{16'hFF00, 16'hE000, 16'h8000, 16'hC000};
  localparam logic [7:0] SEG_PAGE [NUM_MEMS] = '{8'h00, 8'h00, 8'h00, 8'h00};
  localparam logic SEG_PAGE_USE [NUM_MEMS] = '{1'b0, 1'b0, 1'b1, 1'b0};

  // Placement word layout
  localparam int unsigned MAP_W = 5;
  localparam int unsigned MAP_MAIN_PROG = 0;
  localparam int unsigned MAP_MAIN_DATA = 1;
  localparam int unsigned MAP_SEC_PROG = 2;
  localparam int unsigned MAP_SEC_DATA = 3;
  localparam int unsigned MAP_SRAM_PROG = 4;
  localparam logic [MAP_W-1:0] MAP_RST = 5'h09;

  // Reset values
  localparam logic [7:0] PAGE_RST = 8'h00;
  localparam logic [15:0] PTR_RST = 16'h0000;

  // Operations the core sequencer issues, one per machine cycle
  typedef enum logic [3:0] {
    OP_IDLE,
    OP_FETCH,
    OP_JUMP,
    OP_VECTOR,
    OP_XREAD,
    OP_XWRITE,
    OP_PTR_LOAD,
    OP_INTERNAL,
    OP_PAGE_SET,
    OP_MAP_SET
  } op_kind_t;

endpackage

// [hdl/mem_space_decode.sv]
// Machine-cycle bus unit and programmable memory decode for the external spaces.
// Assumes the opcode sequencer sits outside on the same clock and issues one
// operation per machine cycle while op_ready is high; memories answer within three clocks.

module mem_space_decode
  import mem_space_pkg::*;
#(
  parameter int unsigned NUM_PTRS = 2 // Data pointers
) (
  input wire logic clk, // Core clock
  input wire logic reset, // Synchronous reset, active high
  input wire logic [MAP_W-1:0] nv_map, // Nonvolatile placement word
  input wire logic op_valid, // Operation presented
  input wire op_kind_t op_kind, // Operation kind
  input wire logic [15:0] op_jump_addr, // Branch target
  input wire logic [2:0] op_vector, // Interrupt source index
  input wire logic [$clog2(NUM_PTRS)-1:0] op_ptr_sel, // Data pointer select
  input wire logic [15:0] op_ptr_value, // Pointer load value
  input wire logic op_ptr_inc, // Bump pointer after access
  input wire logic [7:0] op_wdata, // Write data, page or placement
  input wire logic [7:0] mem_rdata, // Read data from selected memory
  output logic op_ready, // Next operation taken at end of cycle
  output logic [15:0] mem_addr, // Bus address
  output logic [7:0] mem_page, // Page extension
  output logic [NUM_MEMS-1:0] mem_sel, // One-hot memory select
  output logic program_store_strobe, // Fetch strobe
  output logic read_strobe, // Data read strobe
  output logic write_strobe, // Data write strobe
  output logic [7:0] mem_wdata, // Write data
  output logic [7:0] rd_data, // Captured read or fetch byte
  output logic rd_valid // Capture pulse
);

  if (NUM_PTRS < 2) begin : g_bad_ptrs
    $error("mem_space_decode needs at least two data pointers");
  end

  logic [1:0] phase_q;
  logic boot_q;
  logic pend_q;
  logic [MAP_W-1:0] map_q;
  logic [15:0] ip_q;
  logic [7:0] page_q;
  logic [15:0] data_pointer_reg_q [NUM_PTRS];

  // Operation selection; boot forces the reset-vector fetch
  wire take = (phase_q == PHASE_LAST);
  wire op_kind_t kind_eff = boot_q ? OP_FETCH : (op_valid ? op_kind : OP_IDLE);
  wire is_fetch = (kind_eff == OP_FETCH);
  wire is_xrd = (kind_eff == OP_XREAD);
  wire is_xwr = (kind_eff == OP_XWRITE);
  wire is_ext = is_fetch | is_xrd | is_xwr;
  wire [15:0] bus_addr = is_fetch ? ip_q : data_pointer_reg_q[op_ptr_sel];
  wire [15:0] vec_addr = VEC_BASE + (16'(op_vector) << VEC_SHIFT);

  // Placement in effect; the stored word is only trusted once loaded
  wire [MAP_W-1:0] eff_map = pend_q ? nv_map : map_q;
  wire [NUM_MEMS-1:0] prog_ok = {eff_map[MAP_SEC_PROG], eff_map[MAP_MAIN_PROG],
                                 eff_map[MAP_SRAM_PROG], 1'b0};
  wire [NUM_MEMS-1:0] data_ok = {eff_map[MAP_SEC_DATA], eff_map[MAP_MAIN_DATA],
                                 2'b11};

  // Per-segment match, gated by the space of the access
  logic [NUM_MEMS-1:0] hit;
  for (genvar i = 0; i < NUM_MEMS; i++) begin : g_seg
    wire addr_ok = ((bus_addr & SEG_MASK[i]) == SEG_BASE[i]);
    wire page_ok = !SEG_PAGE_USE[i] || (page_q == SEG_PAGE[i]);
    assign hit[i] = is_ext && addr_ok && page_ok && (is_fetch ? prog_ok[i] : data_ok[i]);
  end

  // Lowest set bit wins so overlapping segments never double-select
  wire [NUM_MEMS-1:0] sel_next = hit & (~hit + 4'h1);

  // Phase counter and boot flag
  always_ff @(posedge clk) begin
    if (reset) begin
      phase_q <= PHASE_LAST;
      boot_q <= 1'b1;
      pend_q <= 1'b1;
    end else begin
      phase_q <= phase_q + 2'h1;
      pend_q <= 1'b0;
      if (take) begin
        boot_q <= 1'b0;
      end
    end
  end

  // Placement: nonvolatile after reset, software override until reset
  always_ff @(posedge clk) begin
    if (reset) begin
      map_q <= MAP_RST;
    end else if (pend_q) begin
      map_q <= nv_map;
    end else if (take && kind_eff == OP_MAP_SET) begin
      map_q <= op_wdata[MAP_W-1:0];
    end
  end

  // Instruction pointer, branches and vectors
  always_ff @(posedge clk) begin
    if (reset) begin
      ip_q <= RESET_VECTOR;
    end else if (take) begin
      unique case (kind_eff)
        OP_FETCH: ip_q <= ip_q + 16'h0001;
        OP_JUMP: ip_q <= op_jump_addr;
        OP_VECTOR: ip_q <= vec_addr;
        default: ip_q <= ip_q;
      endcase
    end
  end

  // Page register
  always_ff @(posedge clk) begin
    if (reset) begin
      page_q <= PAGE_RST;
    end else if (take && kind_eff == OP_PAGE_SET) begin
      page_q <= op_wdata;
    end
  end

  // Independent data pointers with optional post-increment
  for (genvar p = 0; p < NUM_PTRS; p++) begin : g_ptr
    wire mine = (op_ptr_sel == ($clog2(NUM_PTRS))'(p));
    always_ff @(posedge clk) begin
      if (reset) begin
        data_pointer_reg_q[p] <= PTR_RST;
      end else if (take && mine && kind_eff == OP_PTR_LOAD) begin
        data_pointer_reg_q[p] <= op_ptr_value;
      end else if (take && mine && (is_xrd || is_xwr) && op_ptr_inc) begin
        data_pointer_reg_q[p] <= data_pointer_reg_q[p] + 16'h0001;
      end
    end
  end

  // Bus launch at cycle start, strobes drop before the next cycle
  always_ff @(posedge clk) begin
    if (reset) begin
      mem_addr <= 16'h0000;
      mem_page <= 8'h00;
      mem_sel <= '0;
      program_store_strobe <= 1'b0;
      read_strobe <= 1'b0;
      write_strobe <= 1'b0;
      mem_wdata <= 8'h00;
    end else if (take) begin
      mem_addr <= bus_addr;
      mem_page <= page_q;
      mem_sel <= sel_next;
      program_store_strobe <= is_fetch;
      read_strobe <= is_xrd;
      write_strobe <= is_xwr;
      mem_wdata <= op_wdata;
    end else if (phase_q == PHASE_CAPTURE) begin
      mem_sel <= '0;
      program_store_strobe <= 1'b0;
      read_strobe <= 1'b0;
      write_strobe <= 1'b0;
    end
  end

  // Read capture and handshake toward the sequencer
  always_ff @(posedge clk) begin
    if (reset) begin
      rd_data <= 8'h00;
      rd_valid <= 1'b0;
      op_ready <= 1'b0;
    end else begin
      rd_valid <= (phase_q == PHASE_CAPTURE) && (program_store_strobe || read_strobe);
      if ((phase_q == PHASE_CAPTURE) && (program_store_strobe || read_strobe)) begin
        rd_data <= mem_rdata;
      end
      op_ready <= (phase_q == PHASE_CAPTURE);
    end
  end

  // Checks next to the logic they guard
  property p_one_sel;
    @(posedge clk) disable iff (reset) $onehot0(mem_sel);
  endproperty
  a_one_sel: assert property (p_one_sel) else $error("more than one memory select");

  property p_boot;
    @(posedge clk) $fell(reset) |-> ##1 (program_store_strobe && mem_addr == 16'h0000);
  endproperty
  a_boot: assert property (p_boot) else $error("first fetch not at zero");

  property p_cycle;
    @(posedge clk) disable iff (reset)
      $rose(program_store_strobe) |-> program_store_strobe [*3] ##1 !program_store_strobe;
  endproperty
  a_cycle: assert property (p_cycle) else $error("fetch strobe not three of four clocks");

  property p_read_capture;
    @(posedge clk) disable iff (reset) $rose(read_strobe) |-> ##3 rd_valid;
  endproperty
  a_read_capture: assert property (p_read_capture) else $error("read not captured");

  property p_vector;
    @(posedge clk) disable iff (reset)
      (take && !boot_q && op_valid && op_kind == OP_VECTOR) |=> ip_q == $past(vec_addr);
  endproperty
  a_vector: assert property (p_vector) else $error("vector address wrong");

  property p_internal;
    @(posedge clk) disable iff (reset)
      (take && !boot_q && op_valid && op_kind == OP_INTERNAL)
        |=> (!read_strobe && !write_strobe) [*3];
  endproperty
  a_internal: assert property (p_internal) else $error("strobe on internal access");

  property p_no_prog_write;
    @(posedge clk) disable iff (reset)
      write_strobe |-> !program_store_strobe && ((mem_sel & ~data_ok) == '0);
  endproperty
  a_no_prog_write: assert property (p_no_prog_write) else $error("write in program space");

  property p_ctrl_data_only;
    @(posedge clk) disable iff (reset) program_store_strobe |-> !mem_sel[MEM_CTRL];
  endproperty
  a_ctrl_data_only: assert property (p_ctrl_data_only) else $error("control block in program space");

  property p_ready_rate;
    @(posedge clk) disable iff (reset) op_ready |-> ##1 !op_ready ##3 op_ready;
  endproperty
  a_ready_rate: assert property (p_ready_rate) else $error("machine cycle not four clocks");

  property p_ptr_indep;
    @(posedge clk) disable iff (reset)
      (take && !boot_q && op_valid && op_kind == OP_PTR_LOAD && op_ptr_sel == '0)
        |=> $stable(data_pointer_reg_q[1]) && data_pointer_reg_q[0] == $past(op_ptr_value);
  endproperty
  a_ptr_indep: assert property (p_ptr_indep) else $error("data pointers not independent");

  property p_nv_load;
    @(posedge clk) $fell(reset) |=> map_q == $past(nv_map);
  endproperty
  a_nv_load: assert property (p_nv_load) else $error("placement not reloaded");

  property p_override;
    @(posedge clk) disable iff (reset)
      (take && !boot_q && op_valid && op_kind == OP_MAP_SET)
        |=> map_q == $past(op_wdata[MAP_W-1:0]);
  endproperty
  a_override: assert property (p_override) else $error("placement override lost");

endmodule

// [sim/mem_model.sv]
// Behavioural on-package memories answering the decode block's bus.
// Assumes one memory drives the read bus while selected, same clock.
module mem_model (
  input wire logic [3:0] mem_sel, // One-hot select
  input wire logic [15:0] mem_addr, // Bus address
  output logic [7:0] mem_rdata // Answer byte
);
  timeunit 1ns;
  timeprecision 1ps;

  // Selected memory answers address mixed with its select code;
  // an unselected bus shows the inverse, so a stale capture stands out
  assign mem_rdata = (|mem_sel) ? (mem_addr[7:0] ^ {mem_sel, 4'h0}) : ~mem_addr[7:0];
endmodule

// [sim/tb.sv]
// Self-checking bench for the memory space decode block.
// Assumes the block answers on one 50 MHz clock; memories come from mem_model.
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import mem_space_pkg::*;
  logic clk = 0, reset = 1, op_valid = 0, op_ptr_sel = 0, op_ptr_inc = 0;
  logic [4:0] nv_map = 5'h0D;
  op_kind_t op_kind = OP_IDLE;
  logic [15:0] op_jump_addr = 16'h0, op_ptr_value = 16'h0, mem_addr;
  logic [2:0] op_vector = 3'h0;
  logic [7:0] op_wdata = 8'h0, mem_rdata, mem_page, mem_wdata, rd_data;
  logic [3:0] mem_sel;
  logic op_ready, program_store_strobe, read_strobe, write_strobe, rd_valid;
  int bad_count = 0, samples_checked = 0;

  // Clock and block under test
  always #10 clk = ~clk;
  mem_space_decode mem_space_decode_i (.clk(clk), .reset(reset), .nv_map(nv_map),
    .op_valid(op_valid), .op_kind(op_kind), .op_jump_addr(op_jump_addr),
    .op_vector(op_vector), .op_ptr_sel(op_ptr_sel), .op_ptr_value(op_ptr_value),
    .op_ptr_inc(op_ptr_inc), .op_wdata(op_wdata), .mem_rdata(mem_rdata),
    .op_ready(op_ready), .mem_addr(mem_addr), .mem_page(mem_page), .mem_sel(mem_sel),
    .program_store_strobe(program_store_strobe), .read_strobe(read_strobe),
    .write_strobe(write_strobe), .mem_wdata(mem_wdata), .rd_data(rd_data),
    .rd_valid(rd_valid));
  mem_model mem_model_i (.mem_sel(mem_sel), .mem_addr(mem_addr),
    .mem_rdata(mem_rdata));

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    samples_checked++;
    if (got !== exp) begin
      bad_count++;
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One machine cycle: present op at ready, check launch, check completion
  task automatic run(input op_kind_t k, input logic [15:0] a, input logic [7:0] d,
      input logic ps, input logic inc, input logic [3:0] es, input logic [2:0] eb,
      input logic [15:0] ea);
    int n;
    logic [7:0] er;
    n = 0;
    while (op_ready !== 1'b1 && n < 20) begin
      @(posedge clk);
      #1;
      n++;
    end
    op_valid = 1;
    op_kind = k;
    op_jump_addr = a;
    op_ptr_value = a;
    op_vector = a[2:0];
    op_ptr_sel = ps;
    op_ptr_inc = inc;
    op_wdata = d;
    @(posedge clk);
    #1;
    op_valid = 0;
    chk({12'h0, mem_sel}, {12'h0, es});
    chk({13'h0, program_store_strobe, read_strobe, write_strobe}, {13'h0, eb});
    if (eb != 3'h0) chk(mem_addr, ea);
    if (eb[0]) chk({8'h0, mem_wdata}, {8'h0, d});
    repeat (3) begin
      chk({15'h0, op_ready}, 16'h0);
      @(posedge clk);
      #1;
    end
    chk({15'h0, op_ready}, 16'h1);
    chk({15'h0, rd_valid}, {15'h0, eb[2] | eb[1]});
    er = (es == 4'h0) ? ~ea[7:0] : (ea[7:0] ^ {es, 4'h0});
    if (eb[2] | eb[1]) chk({8'h0, rd_data}, {8'h0, er});
  endtask

  // Reset, then watch the boot fetch from the reset vector
  task automatic t_boot();
    reset = 1;
    repeat (4) @(posedge clk);
    #1;
    reset = 0;
    @(posedge clk);
    #1;
    chk({15'h0, program_store_strobe}, 16'h1);
    chk(mem_addr, 16'h0000);
    chk({12'h0, mem_sel}, 16'h0008);
    repeat (3) @(posedge clk);
    #1;
    chk({8'h0, rd_data}, 16'h0080);
    run(OP_FETCH, 16'h0, 8'h0, 0, 0, 4'h8, 3'h4, 16'h0001);
    $display("test boot done");
  endtask

  task automatic t_fetch();
    run(OP_FETCH, 16'h0, 8'h0, 0, 0, 4'h8, 3'h4, 16'h0002);
    run(OP_FETCH, 16'h0, 8'h0, 0, 0, 4'h8, 3'h4, 16'h0003);
    run(OP_JUMP, 16'h3FFF, 8'h0, 0, 0, 4'h0, 3'h0, 16'h0);
    run(OP_FETCH, 16'h0, 8'h0, 0, 0, 4'h8, 3'h4, 16'h3FFF);
    run(OP_FETCH, 16'h0, 8'h0, 0, 0, 4'h0, 3'h4, 16'h4000);
    for (int i = 0; i < 3; i++) begin
      run(OP_VECTOR, 16'(i), 8'h0, 0, 0, 4'h0, 3'h0, 16'h0);
      run(OP_FETCH, 16'h0, 8'h0, 0, 0, 4'h8, 3'h4, 16'(16'h0003 + 8 * i));
    end
    $display("test fetch done");
  endtask

  // Both pointers, post-increment, internal work, SRAM not in program space
  task automatic t_data();
    run(OP_PTR_LOAD, 16'h2010, 8'h0, 0, 0, 4'h0, 3'h0, 16'h0);
    run(OP_PTR_LOAD, 16'h7F05, 8'h0, 1, 0, 4'h0, 3'h0, 16'h0);
    run(OP_XWRITE, 16'h0, 8'hA5, 1, 1, 4'h1, 3'h1, 16'h7F05);
    run(OP_XWRITE, 16'h0, 8'h3C, 1, 0, 4'h1, 3'h1, 16'h7F06);
    run(OP_XREAD, 16'h0, 8'h0, 0, 0, 4'h2, 3'h2, 16'h2010);
    run(OP_INTERNAL, 16'h0, 8'h0, 0, 0, 4'h0, 3'h0, 16'h0);
    run(OP_JUMP, 16'h2000, 8'h0, 0, 0, 4'h0, 3'h0, 16'h0);
    run(OP_FETCH, 16'h0, 8'h0, 0, 0, 4'h8, 3'h4, 16'h2000);
    $display("test data done");
  endtask

  // Runtime placement override, paging, flash update through data space
  task automatic t_map();
    run(OP_MAP_SET, 16'h0, 8'h16, 0, 0, 4'h0, 3'h0, 16'h0);
    run(OP_JUMP, 16'h2000, 8'h0, 0, 0, 4'h0, 3'h0, 16'h0);
    run(OP_FETCH, 16'h0, 8'h0, 0, 0, 4'h2, 3'h4, 16'h2000);
    run(OP_PTR_LOAD, 16'h8000, 8'h0, 0, 0, 4'h0, 3'h0, 16'h0);
    run(OP_XREAD, 16'h0, 8'h0, 0, 0, 4'h4, 3'h2, 16'h8000);
    run(OP_XWRITE, 16'h0, 8'h5A, 0, 0, 4'h4, 3'h1, 16'h8000);
    run(OP_PAGE_SET, 16'h0, 8'h01, 0, 0, 4'h0, 3'h0, 16'h0);
    run(OP_XREAD, 16'h0, 8'h0, 0, 0, 4'h0, 3'h2, 16'h8000);
    chk({8'h0, mem_page}, 16'h0001);
    run(OP_PAGE_SET, 16'h0, 8'h00, 0, 0, 4'h0, 3'h0, 16'h0);
    run(OP_JUMP, 16'h8000, 8'h0, 0, 0, 4'h0, 3'h0, 16'h0);
    run(OP_FETCH, 16'h0, 8'h0, 0, 0, 4'h0, 3'h4, 16'h8000);
    run(OP_PTR_LOAD, 16'h0100, 8'h0, 1, 0, 4'h0, 3'h0, 16'h0);
    run(OP_XREAD, 16'h0, 8'h0, 1, 0, 4'h0, 3'h2, 16'h0100);
    $display("test map done");
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  // Main sequence; second boot shows the override is dropped at reset
  initial begin
    t_boot();
    t_fetch();
    t_data();
    t_map();
    t_boot();
    finish_test();
  end

  // Watchdog, well beyond the roughly 160 cycles the tests need
  initial begin
    #80000;
    bad_count++;
    finish_test();
  end
endmodule
